//--- verilog/ttrb_pkg.sv
/*
  Shared constants for the temperature and test register bank: register
  addresses, field positions, reset values and timing counts.
  Assumes a single 20 MHz reference clock in the device.
  // Behaviour
  // - writing one to trigger bit starts conversion; trigger bit always reads zero
  // - conversion-active bit stays one for the whole conversion
  // - conversion-active bit clears as soon as the conversion finishes
  // - receiver unavailable while converting; host waits for active bit to clear
  // - result is 8-bit read-only, minus one degree per count, needs calibration
  // - lna register: 0x1b normal, 0x2d high sensitivity, resets to 0x1b
  // - fading margin: 0x00 normal, 0x20 with low-index afc, 0x30 without
  // - with low-index afc on, offset equals register value times 488 Hz
  // - internal reset at power-up, and reset pin resets at any time
*/
package ttrb_pkg;
  localparam logic [6:0] ADDR_TEMP_CTRL = 7'h4e;
  localparam logic [6:0] ADDR_TEMP_RESULT = 7'h4f;
  localparam logic [6:0] ADDR_LNA = 7'h58;
  localparam logic [6:0] ADDR_PA_TRIM_A = 7'h5a;
  localparam logic [6:0] ADDR_PA_TRIM_B = 7'h5c;
  localparam logic [6:0] ADDR_FADING = 7'h6f;
  localparam logic [6:0] ADDR_AFC_OFFSET = 7'h71;

  localparam int TRIG_BIT = 3;
  localparam int ACTIVE_BIT = 2;
  localparam logic [1:0] CTRL_LOW_BITS = 2'h1;

  localparam logic [7:0] RST_LNA = 8'h1b;
  localparam logic [7:0] LNA_HIGH_SENS = 8'h2d;
  localparam logic [7:0] RST_PA_TRIM_A = 8'h55;
  localparam logic [7:0] RST_PA_TRIM_B = 8'h70;
  localparam logic [7:0] RST_FADING = 8'h30;
  localparam logic [7:0] RST_AFC_OFFSET = 8'h00;
  localparam logic [7:0] RST_RESULT = 8'h00;

  localparam int REF_CLK_MHZ = 20;
  localparam int TEMP_CONV_TIME_US = 100;
  localparam int TEMP_CONV_CYCLES = TEMP_CONV_TIME_US * REF_CLK_MHZ;
  localparam int STARTUP_TIME_US = 1000;
  localparam int STARTUP_CYCLES = STARTUP_TIME_US * REF_CLK_MHZ;
  localparam int CLK_OUT_HALF_CYCLES = 2;
  localparam logic [16:0] AFC_STEP_HZ = 17'h001e8;
endpackage

//--- verilog/ttrb_temp_conv.sv
/*
  Temperature conversion sequencer: runs a fixed-length conversion on a
  start pulse and captures the sensor code at its end.
  Assumes sensor_code is already synchronised to ref_clk.
*/
`timescale 1ns/10ps
module ttrb_temp_conv
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic soft_rst,
  input wire logic start,
  input wire logic [7:0] sensor_code,
  output logic active,
  output logic [7:0] result
);
  logic [11:0] count;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      active <= 1'b0;
      count <= 12'h000;
    end
    else if (soft_rst)
    begin
      active <= 1'b0;
      count <= 12'h000;
    end
    else if (start && !active)
    begin
      active <= 1'b1;
      count <= 12'(ttrb_pkg::TEMP_CONV_CYCLES - 1);
    end
    else if (active)
    begin
      if (count == 12'h000)
        active <= 1'b0;
      else
        count <= count - 12'h001;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      result <= ttrb_pkg::RST_RESULT;
    else if (soft_rst)
      result <= ttrb_pkg::RST_RESULT;
    else if (active && count == 12'h000)
      result <= sensor_code;
  end
endmodule

//--- verilog/ttrb_bank.sv
/*
  Temperature and test register bank with its spi slave, reset pin
  handling and clock output start-up gate.
  Assumes spi mode 0, first byte = write flag plus 7-bit address, then
  data bytes with auto-incrementing address; pins are asynchronous.
*/
`timescale 1ns/10ps
module ttrb_bank
#(
  parameter int STARTUP_CYCLES = ttrb_pkg::STARTUP_CYCLES
)
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reset_pin,
  input wire logic spi_nss,
  input wire logic spi_sck,
  input wire logic spi_mosi,
  output logic spi_miso,
  output logic spi_miso_oe,
  input wire logic [7:0] sensor_code_pin,
  input wire logic low_index_afc_enable,
  output logic [7:0] lna_gain_select,
  output logic high_sensitivity,
  output logic [7:0] pa_high_power_trim_a,
  output logic [7:0] pa_high_power_trim_b,
  output logic [7:0] fading_margin_setting,
  output logic [7:0] low_index_freq_offset,
  output logic [16:0] afc_offset_hz,
  output logic temp_conversion_active,
  output logic rx_inhibit,
  output logic clock_output_pin
);
  logic [1:0] rst_sync;
  logic [2:0] nss_sync;
  logic [2:0] sck_sync;
  logic [1:0] mosi_sync;
  logic [7:0] code_s1;
  logic [7:0] code_s2;
  logic soft_rst;
  logic sck_rise;
  logic sck_fall;
  logic nss_high;
  logic [2:0] bit_cnt;
  logic [7:0] rx_shift;
  logic [7:0] tx_shift;
  logic [7:0] rx_byte;
  logic have_addr;
  logic wnr;
  logic [6:0] addr;
  logic byte_done;
  logic [6:0] next_addr;
  logic wr_en;
  logic conv_start;
  logic [7:0] temp_reading;
  logic [$clog2(STARTUP_CYCLES + 1) - 1:0] startup_cnt;
  logic ready;
  logic [1:0] div_cnt;

  function automatic logic [7:0] read_reg(input logic [6:0] a);
    unique case (a)
      // trigger bit reads zero; unused bits read defaults
      ttrb_pkg::ADDR_TEMP_CTRL:
        read_reg = {4'h0, 1'b0, temp_conversion_active, ttrb_pkg::CTRL_LOW_BITS};
      ttrb_pkg::ADDR_TEMP_RESULT: read_reg = temp_reading;
      ttrb_pkg::ADDR_LNA: read_reg = lna_gain_select;
      ttrb_pkg::ADDR_PA_TRIM_A: read_reg = pa_high_power_trim_a;
      ttrb_pkg::ADDR_PA_TRIM_B: read_reg = pa_high_power_trim_b;
      ttrb_pkg::ADDR_FADING: read_reg = fading_margin_setting;
      ttrb_pkg::ADDR_AFC_OFFSET: read_reg = low_index_freq_offset;
      default: read_reg = 8'h00;
    endcase
  endfunction

  // pin synchronisers
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      rst_sync <= 2'h0;
      nss_sync <= 3'h7;
      sck_sync <= 3'h0;
      mosi_sync <= 2'h0;
      code_s1 <= 8'h00;
      code_s2 <= 8'h00;
    end
    else
    begin
      rst_sync <= {rst_sync[0], reset_pin};
      nss_sync <= {nss_sync[1:0], spi_nss};
      sck_sync <= {sck_sync[1:0], spi_sck};
      mosi_sync <= {mosi_sync[0], spi_mosi};
      code_s1 <= sensor_code_pin;
      code_s2 <= code_s1;
    end
  end

  // power-up via nrst, reset pin at any time
  assign soft_rst = rst_sync[1];
  assign nss_high = nss_sync[1];
  assign sck_rise = !nss_high && sck_sync[1] && !sck_sync[2];
  assign sck_fall = !nss_high && !sck_sync[1] && sck_sync[2];
  assign rx_byte = {rx_shift[6:0], mosi_sync[1]};
  assign byte_done = sck_rise && bit_cnt == 3'h7;
  assign next_addr = have_addr ? addr + 7'h01 : rx_byte[6:0];
  assign wr_en = byte_done && have_addr && wnr;

  // spi frame: address byte then data bytes
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      bit_cnt <= 3'h0;
      rx_shift <= 8'h00;
      have_addr <= 1'b0;
      wnr <= 1'b0;
      addr <= 7'h00;
    end
    else if (soft_rst || nss_high)
    begin
      bit_cnt <= 3'h0;
      have_addr <= 1'b0;
    end
    else if (sck_rise)
    begin
      bit_cnt <= bit_cnt + 3'h1;
      rx_shift <= rx_byte;
      if (byte_done)
      begin
        have_addr <= 1'b1;
        addr <= next_addr;
        if (!have_addr)
          wnr <= rx_byte[7];
      end
    end
  end

  // read data shifts out msb first on falling clock
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      tx_shift <= 8'h00;
    else if (soft_rst || nss_high)
      tx_shift <= 8'h00;
    else if (byte_done)
      tx_shift <= read_reg(next_addr);
    else if (sck_fall && bit_cnt != 3'h0)
      tx_shift <= {tx_shift[6:0], 1'b0};
  end

  assign spi_miso = tx_shift[7];
  assign spi_miso_oe = !nss_high;

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      lna_gain_select <= ttrb_pkg::RST_LNA;
    else if (soft_rst)
      lna_gain_select <= ttrb_pkg::RST_LNA;
    else if (wr_en && addr == ttrb_pkg::ADDR_LNA)
      lna_gain_select <= rx_byte;
  end

  assign high_sensitivity = lna_gain_select == ttrb_pkg::LNA_HIGH_SENS;

  // amplifier trims, host picks the values
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      pa_high_power_trim_a <= ttrb_pkg::RST_PA_TRIM_A;
      pa_high_power_trim_b <= ttrb_pkg::RST_PA_TRIM_B;
    end
    else if (soft_rst)
    begin
      pa_high_power_trim_a <= ttrb_pkg::RST_PA_TRIM_A;
      pa_high_power_trim_b <= ttrb_pkg::RST_PA_TRIM_B;
    end
    else if (wr_en)
    begin
      if (addr == ttrb_pkg::ADDR_PA_TRIM_A)
        pa_high_power_trim_a <= rx_byte;
      if (addr == ttrb_pkg::ADDR_PA_TRIM_B)
        pa_high_power_trim_b <= rx_byte;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      fading_margin_setting <= ttrb_pkg::RST_FADING;
    else if (soft_rst)
      fading_margin_setting <= ttrb_pkg::RST_FADING;
    else if (wr_en && addr == ttrb_pkg::ADDR_FADING)
      fading_margin_setting <= rx_byte;
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      low_index_freq_offset <= ttrb_pkg::RST_AFC_OFFSET;
    else if (soft_rst)
      low_index_freq_offset <= ttrb_pkg::RST_AFC_OFFSET;
    else if (wr_en && addr == ttrb_pkg::ADDR_AFC_OFFSET)
      low_index_freq_offset <= rx_byte;
  end

  // offset in hz, zero when low-index afc is off
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      afc_offset_hz <= 17'h00000;
    else if (low_index_afc_enable)
      afc_offset_hz <= 17'({9'h000, low_index_freq_offset} * ttrb_pkg::AFC_STEP_HZ);
    else
      afc_offset_hz <= 17'h00000;
  end

  // trigger write starts conversion; other bits ignored
  assign conv_start = wr_en && addr == ttrb_pkg::ADDR_TEMP_CTRL && rx_byte[ttrb_pkg::TRIG_BIT];

  ttrb_temp_conv u_conv
  (
    .ref_clk(ref_clk),
    .nrst(nrst),
    .soft_rst(soft_rst),
    .start(conv_start),
    .sensor_code(code_s2),
    .active(temp_conversion_active),
    .result(temp_reading)
  );

  assign rx_inhibit = temp_conversion_active;

  // start-up wait, then clock output runs
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      startup_cnt <= '0;
      ready <= 1'b0;
    end
    else if (soft_rst)
    begin
      startup_cnt <= '0;
      ready <= 1'b0;
    end
    else if (startup_cnt == ($bits(startup_cnt))'(STARTUP_CYCLES - 1))
      ready <= 1'b1;
    else
      startup_cnt <= startup_cnt + ($bits(startup_cnt))'(1);
  end

  // clock output active only once ready
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      div_cnt <= 2'h0;
      clock_output_pin <= 1'b0;
    end
    else if (!ready)
    begin
      div_cnt <= 2'h0;
      clock_output_pin <= 1'b0;
    end
    else if (div_cnt == 2'(ttrb_pkg::CLK_OUT_HALF_CYCLES - 1))
    begin
      div_cnt <= 2'h0;
      clock_output_pin <= !clock_output_pin;
    end
    else
      div_cnt <= div_cnt + 2'h1;
  end
endmodule

//--- bench/ttrb_host_model.sv
/*
  host model: spi master and manual reset pin driver.
  assumes the 20 MHz ref_clk and a mode 0 slave.
*/
`timescale 1ns/10ps
module ttrb_host_model
(
  input wire logic ref_clk,
  input wire logic spi_miso,
  input wire logic clock_output_pin,
  output logic reset_pin,
  output logic spi_nss,
  output logic spi_sck,
  output logic spi_mosi
);
  initial
  begin
    reset_pin = 1'b0;
    spi_nss = 1'b1;
    spi_sck = 1'b0;
    spi_mosi = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic xbyte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--)
    begin
      spi_mosi <= tx[i];
      tick(6);
      spi_sck <= 1'b1;
      rx[i] = spi_miso;
      tick(6);
      spi_sck <= 1'b0;
    end
  endtask
  task automatic xfer(input logic [7:0] cmd, input logic [7:0] d, output logic [7:0] rx);
    logic [7:0] junk;
    spi_nss <= 1'b0;
    tick(3);
    xbyte(cmd, junk);
    xbyte(d, rx);
    tick(6);
    spi_nss <= 1'b1;
    // released line shows inverse
    spi_mosi <= ~spi_mosi;
    tick(4);
  endtask
  task automatic wait_ready(output bit ok);
    ok = 1'b0;
    for (int i = 0; i < 400 && !ok; i++)
    begin
      tick(1);
      ok = (clock_output_pin === 1'b1);
    end
  endtask
  task automatic pin_reset();
    reset_pin <= 1'b1;
    tick(2000);
    reset_pin <= 1'b0;
  endtask
endmodule

//--- bench/ttrb_bank_asserts.sv
/*
  port checker for the register bank.
  assumes a bind into ttrb_bank.
*/
`timescale 1ns/10ps
module ttrb_bank_asserts
(
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic reset_pin,
  input wire logic spi_nss,
  input wire logic spi_miso_oe,
  input wire logic low_index_afc_enable,
  input wire logic [7:0] lna_gain_select,
  input wire logic high_sensitivity,
  input wire logic [7:0] pa_high_power_trim_a,
  input wire logic [7:0] pa_high_power_trim_b,
  input wire logic [7:0] fading_margin_setting,
  input wire logic [7:0] low_index_freq_offset,
  input wire logic [16:0] afc_offset_hz,
  input wire logic temp_conversion_active,
  input wire logic rx_inhibit,
  input wire logic clock_output_pin
);
  logic [11:0] act_cnt;
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
      act_cnt <= 12'h000;
    else if (temp_conversion_active)
      act_cnt <= act_cnt + 12'h001;
    else
      act_cnt <= 12'h000;
  end
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!nrst);
  property p_sens;
    high_sensitivity == (lna_gain_select == 8'h2d);
  endproperty
  a_sens: assert property (p_sens) else $error("sensitivity flag wrong");
  property p_rx;
    rx_inhibit == temp_conversion_active;
  endproperty
  a_rx: assert property (p_rx) else $error("receive inhibit wrong");
  property p_afc_on;
    low_index_afc_enable |=>
      afc_offset_hz == $past(low_index_freq_offset) * ttrb_pkg::AFC_STEP_HZ;
  endproperty
  a_afc_on: assert property (p_afc_on) else $error("afc offset wrong");
  property p_afc_off;
    !low_index_afc_enable |=> afc_offset_hz == 17'h00000;
  endproperty
  a_afc_off: assert property (p_afc_off) else $error("afc offset not zero");
  property p_run;
    $fell(temp_conversion_active) |-> act_cnt == 12'(ttrb_pkg::TEMP_CONV_CYCLES);
  endproperty
  a_run: assert property (p_run) else $error("conversion cut short");
  property p_done;
    act_cnt == 12'(ttrb_pkg::TEMP_CONV_CYCLES) |-> !temp_conversion_active;
  endproperty
  a_done: assert property (p_done) else $error("active flag stuck");
  property p_pin;
    reset_pin [*5] |-> lna_gain_select == 8'h1b && pa_high_power_trim_a == 8'h55
      && pa_high_power_trim_b == 8'h70 && fading_margin_setting == 8'h30
      && low_index_freq_offset == 8'h00 && !temp_conversion_active;
  endproperty
  a_pin: assert property (p_pin) else $error("pin reset not applied");
  property p_clk;
    disable iff (!nrst || reset_pin)
    $changed(clock_output_pin) |=> $stable(clock_output_pin) ##1 $changed(clock_output_pin);
  endproperty
  a_clk: assert property (p_clk) else $error("clock output period wrong");
  property p_oe_idle;
    spi_nss [*3] |-> !spi_miso_oe;
  endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("miso enable while deselected");
  property p_oe_sel;
    !spi_nss [*3] |-> spi_miso_oe;
  endproperty
  a_oe_sel: assert property (p_oe_sel) else $error("miso enable missing in frame");
endmodule

bind ttrb_bank ttrb_bank_asserts ttrb_bank_asserts_i
(
  .ref_clk, .nrst, .reset_pin, .spi_nss, .spi_miso_oe, .low_index_afc_enable,
  .lna_gain_select, .high_sensitivity,
  .pa_high_power_trim_a, .pa_high_power_trim_b, .fading_margin_setting,
  .low_index_freq_offset, .afc_offset_hz, .temp_conversion_active, .rx_inhibit,
  .clock_output_pin
);

//--- bench/ttrb_bank_tb.sv
/*
  testbench for the register bank over its spi port.
  assumes the host model and the bound checker.
*/
`timescale 1ns/10ps
module ttrb_bank_tb;
  logic ref_clk;
  logic nrst;
  logic reset_pin, spi_nss, spi_sck, spi_mosi, spi_miso, spi_miso_oe;
  logic low_index_afc_enable, high_sensitivity, temp_conversion_active;
  logic rx_inhibit, clock_output_pin;
  logic [7:0] sensor_code_pin, lna_gain_select, pa_high_power_trim_a, pa_high_power_trim_b;
  logic [7:0] fading_margin_setting, low_index_freq_offset;
  logic [16:0] afc_offset_hz;
  int error_cnt = 0;
  int compares = 0;
  bit ok;
  logic [6:0] ra [8] = '{7'h58, 7'h5a, 7'h5c, 7'h6f, 7'h71, 7'h4e, 7'h4f, 7'h10};
  logic [7:0] rv [8] = '{8'h1b, 8'h55, 8'h70, 8'h30, 8'h00, 8'h01, 8'h00, 8'h00};
  logic [6:0] wa [9] = '{7'h58, 7'h5a, 7'h5c, 7'h5a, 7'h5c, 7'h6f, 7'h6f, 7'h6f, 7'h71};
  logic [7:0] wv [9] = '{8'h2d, 8'h5d, 8'h7c, 8'h55, 8'h70, 8'h00, 8'h20, 8'h30, 8'h05};
  ttrb_bank #(.STARTUP_CYCLES(16)) ttrb_bank_i
  (
    .ref_clk, .nrst, .reset_pin, .spi_nss, .spi_sck, .spi_mosi, .spi_miso, .spi_miso_oe,
    .sensor_code_pin, .low_index_afc_enable, .lna_gain_select, .high_sensitivity,
    .pa_high_power_trim_a, .pa_high_power_trim_b, .fading_margin_setting,
    .low_index_freq_offset, .afc_offset_hz, .temp_conversion_active, .rx_inhibit,
    .clock_output_pin
  );
  ttrb_host_model ttrb_host_i
  (
    .ref_clk, .spi_miso, .clock_output_pin, .reset_pin, .spi_nss, .spi_sck, .spi_mosi
  );
  always #25 ref_clk = ~ref_clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    ttrb_host_i.xfer({1'b1, a}, d, r);
  endtask
  task automatic rchk(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] r;
    ttrb_host_i.xfer({1'b0, a}, 8'h00, r);
    chk(r, e);
  endtask
  task automatic final_report();
    if (error_cnt == 0 && compares > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (40000) @(posedge ref_clk);
    error_cnt++;
    final_report();
  end
  initial
  begin
    ref_clk = 1'b0;
    nrst = 1'b0;
    sensor_code_pin = 8'h3c;
    low_index_afc_enable = 1'b0;
    repeat (5) @(posedge ref_clk);
    nrst <= 1'b1;
    ttrb_host_i.wait_ready(ok);
    chk(ok, 1'b1);
    for (int i = 0; i < 8; i++)
      rchk(ra[i], rv[i]);
    for (int i = 0; i < 9; i++)
    begin
      wr(wa[i], wv[i]);
      rchk(wa[i], wv[i]);
    end
    chk(high_sensitivity, 1'b1);
    chk(pa_high_power_trim_a, 8'h55);
    chk(pa_high_power_trim_b, 8'h70);
    chk(fading_margin_setting, 8'h30);
    low_index_afc_enable <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk(afc_offset_hz, 17'h00988);
    wr(7'h4f, 8'haa);
    rchk(7'h4f, 8'h00);
    wr(7'h10, 8'h5a);
    rchk(7'h10, 8'h00);
    wr(7'h4e, 8'hff);
    chk(temp_conversion_active, 1'b1);
    chk(rx_inhibit, 1'b1);
    rchk(7'h4e, 8'h05);
    for (int i = 0; i < 2500 && temp_conversion_active === 1'b1; i++)
      @(posedge ref_clk);
    rchk(7'h4f, 8'h3c);
    sensor_code_pin <= 8'h3d;
    rchk(7'h4f, 8'h3c);
    rchk(7'h4e, 8'h01);
    wr(7'h58, 8'h2d);
    ttrb_host_i.pin_reset();
    ttrb_host_i.wait_ready(ok);
    chk(ok, 1'b1);
    rchk(7'h58, 8'h1b);
    rchk(7'h4f, 8'h00);
    final_report();
  end
endmodule
